//--- shared/nand_cache_op_timing_cfg.svh
// Purpose: Times, command bytes and limits of the NAND operation sequencer
// Assumes: 10 MHz system clock
// Notes: Times are kept in their own unit, cycle counts are derived in the modules
`ifndef NAND_CACHE_OP_TIMING_CFG_SVH
`define NAND_CACHE_OP_TIMING_CFG_SVH
`define NC_CLK_MHZ 10
`define NC_T_WB_NS 100
`define NC_T_ARRAY_READ_US 25
`define NC_T_READ_CACHE_US 25
`define NC_T_COPY_CACHE_US 30
`define NC_T_PLANE_DUMMY_US 10
`define NC_T_PROG_US 700
`define NC_T_RST_IDLE_US 5
`define NC_T_RST_READ_US 5
`define NC_T_RST_PROG_US 10
`define NC_T_RST_ERASE_US 500
`define NC_PARTIAL_MAX 4
`define NC_LAST_COL 4351
`define NC_PAGE_BYTES 4352
`define NC_ECC_SEG_BYTES 512
`define NC_STAT_READY_BIT 6
`define NC_CMD_READ 8'h00
`define NC_CMD_READ_GO 8'h30
`define NC_CMD_READ_SEQ 8'h31
`define NC_CMD_READ_END 8'h3F
`define NC_CMD_COPY_CACHE 8'h3A
`define NC_CMD_SERIAL_IN 8'h80
`define NC_CMD_PLANE2_IN 8'h81
`define NC_CMD_PROG_GO 8'h10
`define NC_CMD_CACHE_GO 8'h15
`define NC_CMD_DUMMY_GO 8'h11
`define NC_CMD_STATUS 8'h70
`define NC_CMD_RESET 8'hFF
`endif

//--- shared/nand_seq_pkg.sv
// Purpose: Types shared by the NAND operation sequencer
// Assumes: Nothing
// Notes: Operation codes are the user-side command set
package nand_seq_pkg;
  typedef enum logic [3:0] {
    OP_READ, OP_READ_SEQ, OP_READ_END, OP_COPY_CACHE, OP_PROG,
    OP_CACHE_PROG, OP_DUMMY, OP_STATUS, OP_RESET
  } op_t;
  typedef enum logic [3:0] {
    S_IDLE, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_WB, S_BUSY, S_RDATA, S_DONE
  } state_t;
  typedef enum logic [1:0] {ACT_IDLE, ACT_READ, ACT_PROG} act_t;
endpackage

//--- rtl/data_fifo.sv
// Purpose: Flop-based FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active-high reset
// Notes: Full and empty come straight from the occupancy count
`timescale 1ns/1ps
module data_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("data_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Handshakes are combinational from the count
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointers, count and storage
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = wp_r + AW'(1);
    end
    if (pop) begin
      rp_nxt = rp_r + AW'(1);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
  end

  // Register stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (rst) cnt_r <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule // data_fifo

//--- rtl/nand_cache_op_timing.sv
// Purpose: Host sequencer driving an asynchronous 8-bit NAND flash through its pins
// Assumes: 10 MHz clk; ready_busy_line and dq_in come from the pins and are synchronised here
// Notes: One operation at a time; write data passes an 8-word FIFO; read bytes are pulses
// What this block does
// R1: Page read busy is bounded by 25 us
// R2: Cache read busy is bounded by 25 us
// R3: Copy cache busy is bounded by 30 us
// R4: Reset recovery bound follows device activity
// R5: Dummy plane program busy bounded by 10 us
// R6: Cache program busy bounded by 700 us
// R7: At most four partial programs per page
// R8: Read data sampled before strobe rise
// R9: Short strobe-high hold tolerated, bus released later
// R10: Single-plane series closes with serial input, confirm
// R11: Cache-confirm end needs status poll then reset
// R12: Second-plane series closes likewise, same poll rule
// R13: Final program after cache allows two page times
// R14: Program columns stay within 0 to 4351
// R15: Never drive data lines while device outputs
// R16: Mark every 512-byte segment for error correction
// R17: Wait for ready, or until the busy bound runs out, before the next command
`timescale 1ns/1ps
`include "nand_cache_op_timing_cfg.svh"
module nand_cache_op_timing import nand_seq_pkg::*; #(
  parameter int FIFO_DEPTH = 8,
  parameter int T_PROG_CYC = `NC_T_PROG_US * `NC_CLK_MHZ,
  parameter int T_FINAL_CYC = 2 * `NC_T_PROG_US * `NC_CLK_MHZ,
  parameter int T_RST_ERASE_CYC = `NC_T_RST_ERASE_US * `NC_CLK_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Operation request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire op_t cmd_op,
  input wire logic cmd_plane2,
  input wire logic [12:0] cmd_col,
  input wire logic [23:0] cmd_row,
  input wire logic [12:0] cmd_len,
  // Program data stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  // Results
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic refused,
  output logic timeout,
  output logic [7:0] status_byte,
  output logic ecc_seg_start,
  // Flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic wp_n,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic [7:0] dq_in,
  input wire logic ready_busy_line
);
  localparam int T_WB_CYC = (`NC_T_WB_NS * `NC_CLK_MHZ + 999) / 1000;
  localparam int WB_WAIT = T_WB_CYC + 3; // Pin register plus two sync stages
  localparam int T_RD_CYC = `NC_T_ARRAY_READ_US * `NC_CLK_MHZ;
  localparam int T_RC_CYC = `NC_T_READ_CACHE_US * `NC_CLK_MHZ;
  localparam int T_CC_CYC = `NC_T_COPY_CACHE_US * `NC_CLK_MHZ;
  localparam int T_DM_CYC = `NC_T_PLANE_DUMMY_US * `NC_CLK_MHZ;
  localparam int T_RI_CYC = `NC_T_RST_IDLE_US * `NC_CLK_MHZ;
  localparam int T_RR_CYC = `NC_T_RST_READ_US * `NC_CLK_MHZ;
  localparam int T_RP_CYC = `NC_T_RST_PROG_US * `NC_CLK_MHZ;
  if (T_FINAL_CYC > 65535 || T_PROG_CYC > 65535 || T_RST_ERASE_CYC > 65535 || T_PROG_CYC < 1) begin : g_bad_t
    $error("busy limits must fit the 16-bit timer");
  end

  // Command byte and shape of each operation
  function automatic logic [7:0] first_cmd(op_t op, logic p2);
    case (op)
      OP_READ, OP_COPY_CACHE: first_cmd = `NC_CMD_READ;
      OP_READ_SEQ: first_cmd = `NC_CMD_READ_SEQ;
      OP_READ_END: first_cmd = `NC_CMD_READ_END;
      OP_PROG, OP_CACHE_PROG, OP_DUMMY: first_cmd = p2 ? `NC_CMD_PLANE2_IN : `NC_CMD_SERIAL_IN; // R10 R12
      OP_STATUS: first_cmd = `NC_CMD_STATUS;
      default: first_cmd = `NC_CMD_RESET;
    endcase
  endfunction
  function automatic logic [7:0] conf_cmd(op_t op);
    case (op)
      OP_READ: conf_cmd = `NC_CMD_READ_GO;
      OP_COPY_CACHE: conf_cmd = `NC_CMD_COPY_CACHE;
      OP_PROG: conf_cmd = `NC_CMD_PROG_GO; // R10 R12
      OP_CACHE_PROG: conf_cmd = `NC_CMD_CACHE_GO;
      default: conf_cmd = `NC_CMD_DUMMY_GO;
    endcase
  endfunction
  function automatic logic is_prog(op_t op);
    is_prog = (op == OP_PROG) || (op == OP_CACHE_PROG) || (op == OP_DUMMY);
  endfunction
  function automatic logic has_addr(op_t op);
    has_addr = is_prog(op) || (op == OP_READ) || (op == OP_COPY_CACHE);
  endfunction
  function automatic logic has_rdata(op_t op);
    has_rdata = (op == OP_READ) || (op == OP_READ_SEQ) || (op == OP_READ_END);
  endfunction
  function automatic logic [15:0] busy_limit(op_t op, act_t act, logic after_cache);
    case (op)
      OP_READ: busy_limit = 16'(T_RD_CYC); // R1
      OP_READ_SEQ, OP_READ_END: busy_limit = 16'(T_RC_CYC); // R2
      OP_COPY_CACHE: busy_limit = 16'(T_CC_CYC); // R3
      OP_DUMMY: busy_limit = 16'(T_DM_CYC); // R5
      OP_CACHE_PROG: busy_limit = 16'(T_PROG_CYC); // R6
      OP_PROG: busy_limit = after_cache ? 16'(T_FINAL_CYC) : 16'(T_PROG_CYC); // R13
      default: busy_limit = (act == ACT_PROG) ? 16'(T_RP_CYC) : (act == ACT_READ) ? 16'(T_RR_CYC) : 16'(T_RI_CYC); // R4
    endcase
  endfunction

  // Two-stage synchronisers on the pin inputs
  logic [1:0] rb_sync_r;
  logic [7:0] dq_s1_r, dq_s2_r;
  logic rb_s;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rb_sync_r <= 2'h0;
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
    end else begin
      rb_sync_r <= {rb_sync_r[0], ready_busy_line};
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end
  assign rb_s = rb_sync_r[1];

  // Write data path through the FIFO; drained only in the data phase
  logic f_valid, f_pop;
  logic [7:0] f_data;
  data_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .rst(rst), .in_valid(wr_valid), .in_ready(wr_ready), .in_data(wr_data),
    .out_valid(f_valid), .out_ready(f_pop), .out_data(f_data)
  );

  // Sequencer state
  state_t st_r, st_nxt;
  op_t op_r, op_nxt, saved_r, saved_nxt;
  logic p2_r, p2_nxt, poll_r, poll_nxt, chain_r, chain_nxt, cache_open_r, cache_open_nxt, final_r, final_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [2:0] ai_r, ai_nxt;
  logic [12:0] col_r, col_nxt, left_r, left_nxt, pos_r, pos_nxt;
  logic [23:0] row_r, row_nxt, last_row_r, last_row_nxt;
  logic [2:0] part_r, part_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  act_t act_r, act_nxt;
  logic [7:0] stat_r, stat_nxt, rdd_r, rdd_nxt, dq_r, dq_nxt;
  logic rdv_r, rdv_nxt, done_r, done_nxt, ref_r, ref_nxt, to_r, to_nxt, ecc_r, ecc_nxt;
  logic ce_n_r, ce_n_nxt, cle_r, cle_nxt, ale_r, ale_nxt, we_n_r, we_n_nxt, re_n_r, re_n_nxt, oe_r, oe_nxt;
  logic bad_req, same_row;
  logic [7:0] addr_byte;

  assign cmd_ready = (st_r == S_IDLE);
  assign same_row = (cmd_row == last_row_r);
  assign bad_req = ((has_rdata(cmd_op) || is_prog(cmd_op)) && (14'(cmd_col) + 14'(cmd_len) > 14'(`NC_PAGE_BYTES))) // R14
                 || (is_prog(cmd_op) && same_row && part_r == 3'(`NC_PARTIAL_MAX)); // R7
  assign f_pop = (st_r == S_WDATA) && (ph_r == 2'h0) && f_valid;
  always_comb begin
    case (ai_r)
      3'h0: addr_byte = col_r[7:0];
      3'h1: addr_byte = {3'h0, col_r[12:8]};
      3'h2: addr_byte = row_r[7:0];
      3'h3: addr_byte = row_r[15:8];
      default: addr_byte = row_r[23:16];
    endcase
  end

  // Next state, counters and pin levels; pins are registered so all edges line up
  always_comb begin
    st_nxt = st_r; op_nxt = op_r; saved_nxt = saved_r; p2_nxt = p2_r; poll_nxt = poll_r;
    chain_nxt = chain_r; cache_open_nxt = cache_open_r; final_nxt = final_r; ph_nxt = ph_r;
    ai_nxt = ai_r; col_nxt = col_r; left_nxt = left_r; pos_nxt = pos_r; row_nxt = row_r;
    last_row_nxt = last_row_r; part_nxt = part_r; tmr_nxt = tmr_r; act_nxt = act_r; stat_nxt = stat_r;
    rdd_nxt = rdd_r; dq_nxt = dq_r; rdv_nxt = 1'b0; done_nxt = 1'b0; ref_nxt = 1'b0; to_nxt = 1'b0;
    ecc_nxt = 1'b0; ce_n_nxt = 1'b0; cle_nxt = 1'b0; ale_nxt = 1'b0; we_n_nxt = 1'b1; re_n_nxt = 1'b1;
    oe_nxt = 1'b0;
    case (st_r)
      S_IDLE: begin
        ce_n_nxt = 1'b1;
        if (cmd_valid && bad_req) begin
          ref_nxt = 1'b1;
        end else if (cmd_valid) begin
          p2_nxt = cmd_plane2; col_nxt = cmd_col; row_nxt = cmd_row; left_nxt = cmd_len;
          pos_nxt = cmd_col; ph_nxt = 2'h0; ai_nxt = 3'h0; st_nxt = S_CMD1;
          final_nxt = cache_open_r && (cmd_op == OP_PROG); // R13
          if (is_prog(cmd_op)) begin
            part_nxt = same_row ? part_r + 3'h1 : 3'h1; // R7
            last_row_nxt = cmd_row;
          end
          if (cache_open_r && !is_prog(cmd_op)) begin
            op_nxt = OP_STATUS; poll_nxt = 1'b1; chain_nxt = 1'b1; saved_nxt = cmd_op; // R11 R12
          end else begin
            op_nxt = cmd_op;
          end
        end
      end
      S_CMD1, S_CMD2, S_ADDR: begin
        cle_nxt = (st_r != S_ADDR);
        ale_nxt = (st_r == S_ADDR);
        we_n_nxt = (ph_r != 2'h0);
        dq_nxt = (st_r == S_ADDR) ? addr_byte : (st_r == S_CMD1) ? first_cmd(op_r, p2_r) : conf_cmd(op_r);
        oe_nxt = 1'b1; // R15
        ph_nxt = ph_r + 2'h1;
        if (ph_r == 2'h1) begin
          ph_nxt = 2'h0;
          if (st_r == S_ADDR) begin
            ai_nxt = ai_r + 3'h1;
            if (ai_r == 3'h4) begin
              st_nxt = (is_prog(op_r) && left_r != 13'h0) ? S_WDATA : S_CMD2;
            end
          end else if (st_r == S_CMD1 && has_addr(op_r)) begin
            st_nxt = S_ADDR;
          end else if (st_r == S_CMD1 && op_r == OP_STATUS) begin
            st_nxt = S_RDATA;
          end else begin
            st_nxt = S_WB; tmr_nxt = 16'(WB_WAIT);
            act_nxt = is_prog(op_r) ? ACT_PROG : (op_r == OP_RESET) ? act_r : ACT_READ;
            if (op_r == OP_CACHE_PROG) cache_open_nxt = 1'b1;
            if (op_r == OP_PROG || op_r == OP_RESET) cache_open_nxt = 1'b0; // R10 R11
          end
        end
      end
      S_WDATA: begin
        oe_nxt = 1'b1; // R15
        if (ph_r == 2'h0 && f_valid) begin
          dq_nxt = f_data; we_n_nxt = 1'b0; ph_nxt = 2'h1;
          ecc_nxt = (pos_r % 13'(`NC_ECC_SEG_BYTES)) == 13'h0; // R16
        end else if (ph_r == 2'h1) begin
          ph_nxt = 2'h0; pos_nxt = pos_r + 13'h1; left_nxt = left_r - 13'h1; // R14
          if (left_r == 13'h1) st_nxt = S_CMD2;
        end
      end
      S_WB: begin
        tmr_nxt = tmr_r - 16'h1;
        if (tmr_r == 16'h1) begin
          st_nxt = S_BUSY; tmr_nxt = busy_limit(op_r, act_r, final_r);
        end
      end
      S_BUSY: begin
        tmr_nxt = tmr_r - 16'h1;
        if (rb_s) begin // R17
          act_nxt = ACT_IDLE; ph_nxt = 2'h0;
          st_nxt = (has_rdata(op_r) && left_r != 13'h0) ? S_RDATA : S_DONE;
        end else if (tmr_r == 16'h0) begin
          to_nxt = 1'b1; st_nxt = S_DONE; chain_nxt = 1'b0; poll_nxt = 1'b0;
        end
      end
      S_RDATA: begin
        re_n_nxt = ph_r[1];
        ph_nxt = ph_r + 2'h1;
        if (ph_r == 2'h3) begin
          rdd_nxt = dq_s2_r; // R8 R9
          if (op_r == OP_STATUS) stat_nxt = dq_s2_r;
          rdv_nxt = (op_r != OP_STATUS) || !poll_r;
          ecc_nxt = rdv_nxt && (pos_r % 13'(`NC_ECC_SEG_BYTES)) == 13'h0; // R16
          pos_nxt = pos_r + 13'(!poll_r); left_nxt = left_r - 13'(!poll_r);
          if (left_r == 13'h1 || op_r == OP_STATUS) st_nxt = S_DONE;
        end
      end
      S_DONE: begin
        ph_nxt = 2'h0; ai_nxt = 3'h0; ce_n_nxt = 1'b1; // R15
        if (poll_r && !stat_r[`NC_STAT_READY_BIT]) begin
          st_nxt = S_CMD1; // R11
        end else if (poll_r) begin
          poll_nxt = 1'b0; op_nxt = OP_RESET; st_nxt = S_CMD1; // R11 R12
        end else if (chain_r) begin
          chain_nxt = 1'b0; op_nxt = saved_r; st_nxt = S_CMD1;
        end else begin
          done_nxt = 1'b1; st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // Register stage of the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= S_IDLE; op_r <= OP_RESET; saved_r <= OP_RESET; p2_r <= 1'b0; poll_r <= 1'b0;
      chain_r <= 1'b0; cache_open_r <= 1'b0; final_r <= 1'b0; ph_r <= 2'h0; ai_r <= 3'h0;
      col_r <= 13'h0; left_r <= 13'h0; pos_r <= 13'h0; row_r <= 24'h0; last_row_r <= 24'hFFFFFF;
      part_r <= 3'h0; tmr_r <= 16'h0; act_r <= ACT_IDLE; stat_r <= 8'h00; rdd_r <= 8'h00;
      dq_r <= 8'h00; rdv_r <= 1'b0; done_r <= 1'b0; ref_r <= 1'b0; to_r <= 1'b0; ecc_r <= 1'b0;
      ce_n_r <= 1'b1; cle_r <= 1'b0; ale_r <= 1'b0; we_n_r <= 1'b1; re_n_r <= 1'b1; oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt; op_r <= op_nxt; saved_r <= saved_nxt; p2_r <= p2_nxt; poll_r <= poll_nxt;
      chain_r <= chain_nxt; cache_open_r <= cache_open_nxt; final_r <= final_nxt; ph_r <= ph_nxt;
      ai_r <= ai_nxt; col_r <= col_nxt; left_r <= left_nxt; pos_r <= pos_nxt; row_r <= row_nxt;
      last_row_r <= last_row_nxt; part_r <= part_nxt; tmr_r <= tmr_nxt; act_r <= act_nxt;
      stat_r <= stat_nxt; rdd_r <= rdd_nxt; dq_r <= dq_nxt; rdv_r <= rdv_nxt; done_r <= done_nxt;
      ref_r <= ref_nxt; to_r <= to_nxt; ecc_r <= ecc_nxt; ce_n_r <= ce_n_nxt; cle_r <= cle_nxt;
      ale_r <= ale_nxt; we_n_r <= we_n_nxt; re_n_r <= re_n_nxt; oe_r <= oe_nxt;
    end
  end

  // Outputs from flops except wp_n, tied high; write protect kept off since the block programs
  assign rd_valid = rdv_r; assign rd_data = rdd_r; assign done = done_r; assign refused = ref_r;
  assign timeout = to_r; assign status_byte = stat_r; assign ecc_seg_start = ecc_r;
  assign ce_n = ce_n_r; assign cle = cle_r; assign ale = ale_r; assign write_strobe_n = we_n_r;
  assign read_strobe_n = re_n_r; assign dq_out = dq_r; assign dq_oe = oe_r; assign wp_n = 1'b1;

  // Checks on the pin sequence and the sequencer state
  a_no_bus_fight: assert property (@(posedge clk) disable iff (rst) dq_oe |-> read_strobe_n) // R15
    else $error("data driven while read strobe low");
  a_read_gap: assert property (@(posedge clk) disable iff (rst) !read_strobe_n |=> ##1 !dq_oe) // R15
    else $error("drive too soon after read");
  a_partial_cap: assert property (@(posedge clk) disable iff (rst) part_r <= 3'(`NC_PARTIAL_MAX)) // R7
    else $error("partial program count over limit");
  a_col_range: assert property (@(posedge clk) disable iff (rst) f_pop |-> pos_r <= 13'(`NC_LAST_COL)) // R14
    else $error("program column past page end");
  a_poll_then_reset: assert property (@(posedge clk) disable iff (rst)
    (st_r == S_DONE && poll_r && stat_r[`NC_STAT_READY_BIT]) |=> (op_r == OP_RESET && st_r == S_CMD1)) // R11
    else $error("no reset after status poll");
  a_busy_holds: assert property (@(posedge clk) disable iff (rst)
    (st_r == S_BUSY && !rb_s && tmr_r != 16'h0) |=> st_r == S_BUSY) // R17
    else $error("left busy wait early");
  a_read_bound: assert property (@(posedge clk) disable iff (rst)
    (st_r == S_WB && tmr_r == 16'h1 && op_r == OP_READ) |=> tmr_r == 16'(T_RD_CYC)) // R1
    else $error("read busy limit wrong");
  a_final_bound: assert property (@(posedge clk) disable iff (rst)
    (st_r == S_BUSY && op_r == OP_PROG) |-> tmr_r <= (final_r ? 16'(T_FINAL_CYC) : 16'(T_PROG_CYC))) // R13
    else $error("final program limit wrong");
  a_strobe_excl: assert property (@(posedge clk) disable iff (rst)
    !write_strobe_n |-> (!ce_n && read_strobe_n && !(cle && ale))) // R10
    else $error("bad write cycle pins");
  c_read_done: cover property (@(posedge clk) disable iff (rst) rd_valid ##[1:60] done);
  c_prog_done: cover property (@(posedge clk) disable iff (rst) f_pop ##[1:300] done);
  c_poll_chain: cover property (@(posedge clk) disable iff (rst) (poll_r && op_r == OP_STATUS) ##[1:500] op_r == OP_RESET);
  c_timeout: cover property (@(posedge clk) disable iff (rst) timeout);
endmodule // nand_cache_op_timing

//--- bench/flash_model.sv
// Purpose: Behavioural flash die answering the sequencer's pins
// Assumes: Pins change only on clk edges, so the die samples them on falling clk
// Notes: Busy is short unless slow is set, which overruns every controller limit
`timescale 1ns/1ps
module flash_model (
  // Sampling clock
  input wire logic clk,
  // Pins from the controller
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  // Scenario control
  input wire logic slow,
  // Pins to the controller
  output logic [7:0] dq_in,
  output logic ready_busy_line
);
  int busy = 0;
  int resets = 0;
  int clash = 0;
  logic [12:0] col = '0;
  logic [2:0] na = '0;
  logic stat = 1'b0;
  logic drv = 1'b0;
  logic seen81 = 1'b0;
  logic [7:0] last_cmd = '0;
  logic [7:0] wq[$];
  logic wp = 1'b1;
  logic rp = 1'b1;
  logic [2:0] pc = '0;
  initial dq_in = 8'hC3;
  // Ready only once the busy count has run out, inside each bound unless slow is set
  assign ready_busy_line = (busy == 0);
  // Latch bytes on the rising write strobe
  always @(negedge clk) begin
    wp <= write_strobe_n;
    rp <= read_strobe_n;
    pc <= {ce_n, ale, cle};
    if (busy > 0) busy <= busy - 1;
    if (drv && dq_oe) clash <= clash + 1;
    if (!ce_n && !wp && write_strobe_n) begin
      if (cle) begin
        last_cmd <= dq_out;
        stat <= (dq_out == 8'h70);
        na <= '0;
        if (dq_out inside {8'h30, 8'h31, 8'h3F, 8'h3A, 8'h10, 8'h15, 8'h11, 8'hFF}) busy <= slow ? 900 : 20;
        if (dq_out inside {8'h31, 8'h3F}) col <= '0;
        if (dq_out == 8'hFF) resets <= resets + 1;
        if (dq_out == 8'h81) seen81 <= 1'b1;
      end else if (ale) begin
        if (na == 0) col[7:0] <= dq_out;
        if (na == 1) col[12:8] <= dq_out[4:0];
        na <= na + 1;
      end else wq.push_back(dq_out);
    end
    // Outputs stay on after the strobe rises; a latch, select or write edge turns them off
    if (!ce_n && rp && !read_strobe_n) begin
      drv <= 1'b1;
      dq_in <= stat ? (busy == 0 ? 8'hE0 : 8'hA0) : col[7:0] ^ 8'h5A;
      if (!stat) col <= col + 1;
    end else if (drv && ((cle && !pc[0]) || (ale && !pc[1]) || (ce_n && !pc[2]) || (wp && !write_strobe_n))) begin
      drv <= 1'b0;
      dq_in <= ~dq_in;
    end
  end
endmodule // flash_model

//--- bench/testbench.sv
// Purpose: Self-checking bench for the NAND operation sequencer
// Assumes: flash_model stands on the pins; shortened program counts
// Notes: Ordinary operations come from a table, awkward cases follow by hand
`timescale 1ns/1ps
module testbench import nand_seq_pkg::*;;
  typedef struct packed {op_t op; logic [12:0] col; logic [12:0] len; logic rej;} row_t;
  logic clk = 0, rst = 1, cmd_valid = 0, cmd_plane2 = 0, wr_valid = 0, slow = 0;
  op_t cmd_op = OP_STATUS;
  logic [12:0] cmd_col = '0, cmd_len = '0;
  logic [23:0] cmd_row = '0;
  logic [7:0] wr_data = '0, rd_data, status_byte, dq_out, dq_in;
  logic cmd_ready, wr_ready, rd_valid, done, refused, timeout, ecc_seg_start;
  logic ce_n, cle, ale, write_strobe_n, read_strobe_n, wp_n, dq_oe, ready_busy_line;
  int bad_count = 0, comparisons = 0, ecc_n, e, r0, n0;
  logic saw_ref, saw_to;
  logic [12:0] base;
  logic [7:0] rxq[$];
  row_t rows[9] = '{'{OP_READ, 13'h0, 13'h4, 1'b0}, '{OP_READ, 13'h1FE, 13'h4, 1'b0},
    '{OP_COPY_CACHE, 13'h0, 13'h0, 1'b0}, '{OP_READ_SEQ, 13'h0, 13'h3, 1'b0}, '{OP_READ_END, 13'h0, 13'h2, 1'b0},
    '{OP_READ, 13'h10FE, 13'h2, 1'b0}, '{OP_READ, 13'h10FF, 13'h2, 1'b1},
    '{OP_STATUS, 13'h0, 13'h1, 1'b0}, '{OP_RESET, 13'h0, 13'h0, 1'b0}};
  nand_cache_op_timing #(.FIFO_DEPTH(8), .T_PROG_CYC(200), .T_FINAL_CYC(400), .T_RST_ERASE_CYC(100))
    nand_cache_op_timing_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_plane2(cmd_plane2), .cmd_col(cmd_col), .cmd_row(cmd_row), .cmd_len(cmd_len), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
    .refused(refused), .timeout(timeout), .status_byte(status_byte), .ecc_seg_start(ecc_seg_start),
    .ce_n(ce_n), .cle(cle), .ale(ale), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .wp_n(wp_n), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ready_busy_line(ready_busy_line));
  flash_model flash_model_i (.clk(clk), .ce_n(ce_n), .cle(cle), .ale(ale), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .dq_out(dq_out), .dq_oe(dq_oe), .slow(slow), .dq_in(dq_in),
    .ready_busy_line(ready_busy_line));
  // Clock of 100 ns
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic complete_run;
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check1(input string nm, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin bad_count++; $display("[FAIL] %s expected %b seen %b", nm, exp, got); end
  endtask
  task automatic check8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin bad_count++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); end
  endtask
  // Each byte offered until the buffer takes it
  task automatic feed(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      wr_valid <= 1'b1;
      wr_data <= 8'h30 + 8'(i);
      @(negedge clk);
      while (wr_ready !== 1'b1) @(negedge clk);
    end
    @(posedge clk);
    wr_valid <= 1'b0;
  endtask
  // Request held until taken; pulses read mid-cycle, once settled
  task automatic run_op(input op_t op, input logic p2, input logic [12:0] col, input logic [23:0] row,
                        input logic [12:0] len);
    logic fin;
    fin = 1'b0;
    rxq.delete();
    saw_ref = 1'b0;
    saw_to = 1'b0;
    ecc_n = 0;
    @(posedge clk);
    cmd_op <= op; cmd_plane2 <= p2; cmd_col <= col; cmd_row <= row; cmd_len <= len; cmd_valid <= 1'b1;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (int n = 0; n < 20000 && !fin; n++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) rxq.push_back(rd_data);
      if (rd_valid === 1'b1 && ecc_seg_start === 1'b1) ecc_n++;
      if (timeout === 1'b1) saw_to = 1'b1;
      if (refused === 1'b1) saw_ref = 1'b1;
      fin = (done === 1'b1) || saw_ref;
    end
    check1("op_end", 1'b1, fin);
  endtask
  // Watchdog beyond the expected run length
  initial begin
    #(90000 * 100);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Table of plain operations
    foreach (rows[k]) begin
      run_op(rows[k].op, 1'b0, rows[k].col, 24'h000100, rows[k].len);
      check1("refused", rows[k].rej, saw_ref);
      check8("bytes", rows[k].rej ? 8'h00 : 8'(rows[k].len), 8'(rxq.size()));
      base = (rows[k].op == OP_READ) ? rows[k].col : 13'h0;
      e = 0;
      foreach (rxq[i]) begin
        check8("rd_data", rows[k].op == OP_STATUS ? 8'hE0 : 8'(base + 13'(i)) ^ 8'h5A, rxq[i]);
        if ((base + 13'(i)) % 512 == 0) e++;
      end
      if (rows[k].op == OP_READ) check8("ecc_marks", 8'(e), 8'(ecc_n));
      if (rows[k].op == OP_STATUS) check8("status_byte", 8'hE0, status_byte);
    end
    // Four partial programs on one row, a fifth is refused
    for (int k = 0; k < 5; k++) begin
      fork
        feed(k < 4 ? 2 : 0);
        run_op(OP_PROG, 1'b0, 13'(k * 2), 24'h000005, 13'h2);
      join
      check1("refused", k == 4, saw_ref);
    end
    check8("prog_bytes", 8'h08, 8'(flash_model_i.wq.size()));
    check8("prog_data", 8'h30, flash_model_i.wq[0]);
    check8("last_cmd", 8'h10, flash_model_i.last_cmd);
    // Open cache series on plane two: next request polls, then resets
    r0 = flash_model_i.resets;
    fork
      feed(2);
      run_op(OP_CACHE_PROG, 1'b1, 13'h0, 24'h000009, 13'h2);
    join
    check1("seen81", 1'b1, flash_model_i.seen81);
    run_op(OP_READ, 1'b0, 13'h0, 24'h000009, 13'h1);
    check8("resets", 8'(r0 + 1), 8'(flash_model_i.resets));
    check8("rd_data", 8'h5A, rxq[0]);
    // Fill the idle buffer, then a dummy program empties it
    feed(8);
    @(negedge clk);
    check1("wr_ready", 1'b0, wr_ready);
    n0 = flash_model_i.wq.size();
    run_op(OP_DUMMY, 1'b0, 13'h0, 24'h00000B, 13'h8);
    check8("drained", 8'h08, 8'(flash_model_i.wq.size() - n0));
    check1("wr_ready", 1'b1, wr_ready);
    check8("clash", 8'h00, 8'(flash_model_i.clash));
    // Device overruns its busy bound: controller gives up
    slow <= 1'b1;
    run_op(OP_READ, 1'b0, 13'h0, 24'h000001, 13'h1);
    check1("timeout", 1'b1, saw_to);
    slow <= 1'b0;
    repeat (1000) @(posedge clk);
    run_op(OP_RESET, 1'b0, 13'h0, 24'h0, 13'h0);
    check1("timeout", 1'b0, saw_to);
    // Reset between operations keeps the pins idle
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    check1("ce_n", 1'b1, ce_n);
    check1("dq_oe", 1'b0, dq_oe);
    check1("wp_n", 1'b1, wp_n);
    check1("cmd_ready", 1'b1, cmd_ready);
    rst <= 1'b0;
    run_op(OP_STATUS, 1'b0, 13'h0, 24'h0, 13'h1);
    check8("status_byte", 8'hE0, status_byte);
    complete_run();
  end
endmodule // testbench
